// ==== rtl/dpsc_defs.svh ====
// Register map, field positions, reset values and sizes of the PLL and reference control slice.
//
// Function
// - Reference receiver powered down while control bit 4 set; resets to one.
// - Hysteresis setting reaches the receiver only while enable bit 3 is set.
// - Edge-select bit 2 zero samples on falling edge, one on rising edge.
// - Ten-bit thermometer hysteresis: bits 9:8 in first register, 7:0 in next.
// - While synthesizer enable bit 4 is set, a zero-to-one change of recalibrate bit 7 starts one recalibration only.
// - Synthesizer enable bit 4 enables the PLL and runs calibration; resets zero.
// - Status bit 7 shows the PLL at the upper edge of its band.
// - Status bit 6 shows the PLL at the lower edge of its band.
// - Status bit 5 shows successful calibration; reads zero after reset.
// - Status bit 1 shows PLL lock.
// - Eight-bit integer word is the feedback divider; resets to eight.
// - Converter clock is reference over division ratio, times two, times word.
// - VCO divider select 01, 10, 11 divides by four, eight, sixteen.
// - Reference division codes 000 to 100 divide by 1, 2, 4, 8, 16.
`ifndef DPSC_DEFS_SVH
`define DPSC_DEFS_SVH

// ==========================================================================
// Access port sizes
`define DPSC_ADDR_W        12
`define DPSC_DATA_W        8

// ==========================================================================
// Register offsets
`define DPSC_OFS_REFRX     12'h081
`define DPSC_OFS_HYSLO     12'h082
`define DPSC_OFS_PLLCTL    12'h083
`define DPSC_OFS_PLLSTAT   12'h084
`define DPSC_OFS_INTDIV    12'h085
`define DPSC_OFS_LFA       12'h087
`define DPSC_OFS_LFB       12'h088

// ==========================================================================
// Field positions
`define DPSC_BIT_PWRDN     4
`define DPSC_BIT_HYSEN     3
`define DPSC_BIT_EDGE      2
`define DPSC_BIT_RECAL     7
`define DPSC_BIT_SYNTH     4
`define DPSC_BIT_BANDHI    7
`define DPSC_BIT_BANDLO    6
`define DPSC_BIT_CALOK     5
`define DPSC_BIT_LOCK      1

// ==========================================================================
// Reset values
`define DPSC_RST_PWRDN     1'b1
`define DPSC_RST_INTDIV    8'h08
`define DPSC_RST_LFWORD    4'h8

`endif

// ==== rtl/dpsc_pkg.sv ====
// Types shared by the PLL and reference control slice.
package dpsc_pkg;

  // Software-written control state.
  typedef struct packed {
    logic       refrx_powerdown;
    logic       hysteresis_enable;
    logic       ref_sample_edge_select;
    logic [9:0] hysteresis_thermometer;
    logic       pll_recalibrate;
    logic       synth_enable;
    logic [7:0] int_word;
    logic [3:0] filter_cap2_word;
    logic [3:0] filter_cap1_word;
    logic [3:0] filter_res1_word;
    logic [3:0] filter_cap3_word;
  } dpsc_ctrl_t;

  // Status levels reported by the PLL.
  typedef struct packed {
    logic pll_band_high_flag;
    logic pll_band_low_flag;
    logic pll_calibrated_flag;
    logic pll_locked_flag;
  } dpsc_stat_t;

  // Frequency plan derived from the divider settings.
  typedef struct packed {
    logic [8:0]  dac_mult;
    logic [12:0] vco_mult;
    logic [4:0]  ref_div;
  } dpsc_freq_t;

endpackage : dpsc_pkg

// ==== rtl/dpsc_regs.sv ====
// Control and status registers for the converter clock PLL and alignment-reference receiver.
`timescale 1ns/100ps
`include "dpsc_defs.svh"
module dpsc_regs
  import dpsc_pkg::*;
(
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RESET,
  // Register access from the serial configuration port
  input  wire logic                      REG_WR,
  input  wire logic                      REG_RD,
  input  wire logic [`DPSC_ADDR_W-1:0]   REG_ADDR,
  input  wire logic [`DPSC_DATA_W-1:0]   REG_WDATA,
  output logic      [`DPSC_DATA_W-1:0]   REG_RDATA,
  output logic                           REG_RVALID,
  // Divider selects held by neighbouring registers
  input  wire logic [1:0]                VCO_DIVIDER_SELECT,
  input  wire logic [2:0]                REFERENCE_DIVISION_RATIO,
  // PLL status levels
  input  wire dpsc_stat_t                PLL_STATUS,
  // Alignment-reference receiver controls
  output logic                           REFRX_POWERDOWN,
  output logic                           HYSTERESIS_ENABLE,
  output logic [9:0]                     HYSTERESIS_APPLIED,
  output logic                           REF_SAMPLE_RISE,
  // PLL controls
  output logic                           SYNTH_ENABLE,
  output logic                           CAL_START,
  output logic [7:0]                     FEEDBACK_DIVIDER,
  output logic [15:0]                    LOOP_FILTER,
  output dpsc_freq_t                     FREQ_PLAN
);

  // ==========================================================================
  // Control register file
  dpsc_ctrl_t ctrl;
  dpsc_ctrl_t next_ctrl;

  always_comb begin
    next_ctrl = ctrl;
    if (REG_WR) begin
      unique case (REG_ADDR)
        `DPSC_OFS_REFRX: begin
          next_ctrl.refrx_powerdown        = REG_WDATA[`DPSC_BIT_PWRDN];
          next_ctrl.hysteresis_enable      = REG_WDATA[`DPSC_BIT_HYSEN];
          next_ctrl.ref_sample_edge_select = REG_WDATA[`DPSC_BIT_EDGE];
          next_ctrl.hysteresis_thermometer[9:8] = REG_WDATA[1:0];
        end
        `DPSC_OFS_HYSLO: begin
          next_ctrl.hysteresis_thermometer[7:0] = REG_WDATA;
        end
        `DPSC_OFS_PLLCTL: begin
          // Only the two documented bits are stored; the rest are dropped.
          next_ctrl.pll_recalibrate = REG_WDATA[`DPSC_BIT_RECAL];
          next_ctrl.synth_enable    = REG_WDATA[`DPSC_BIT_SYNTH];
        end
        `DPSC_OFS_INTDIV: begin
          // A word below six is stored as written; keeping it legal is up to software.
          next_ctrl.int_word = REG_WDATA;
        end
        `DPSC_OFS_LFA: begin
          next_ctrl.filter_cap2_word = REG_WDATA[7:4];
          next_ctrl.filter_cap1_word = REG_WDATA[3:0];
        end
        `DPSC_OFS_LFB: begin
          next_ctrl.filter_res1_word = REG_WDATA[7:4];
          next_ctrl.filter_cap3_word = REG_WDATA[3:0];
        end
        default: begin
          next_ctrl = ctrl;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl.refrx_powerdown        <= `DPSC_RST_PWRDN;
      ctrl.hysteresis_enable      <= 1'b0;
      ctrl.ref_sample_edge_select <= 1'b0;
      ctrl.hysteresis_thermometer <= 10'h000;
      ctrl.pll_recalibrate        <= 1'b0;
      ctrl.synth_enable           <= 1'b0;
      ctrl.int_word               <= `DPSC_RST_INTDIV;
      ctrl.filter_cap2_word       <= `DPSC_RST_LFWORD;
      ctrl.filter_cap1_word       <= `DPSC_RST_LFWORD;
      ctrl.filter_res1_word       <= `DPSC_RST_LFWORD;
      ctrl.filter_cap3_word       <= `DPSC_RST_LFWORD;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ==========================================================================
  // Calibration triggers
  // Recalibration fires on the stored bit's rising edge, so rewriting a one
  // while it already reads one does not start another calibration.
  logic recal_pulse;
  logic enable_pulse;

  dpsc_rise_det u_recal_edge (
    .clk   (CLK),
    .reset (RESET),
    .level (ctrl.pll_recalibrate),
    .pulse (recal_pulse)
  );

  dpsc_rise_det u_enable_edge (
    .clk   (CLK),
    .reset (RESET),
    .level (ctrl.synth_enable),
    .pulse (enable_pulse)
  );

  // ==========================================================================
  // Status capture
  dpsc_stat_t stat;
  dpsc_stat_t next_stat;

  always_comb begin
    next_stat = PLL_STATUS;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      stat <= '0;
    end else begin
      stat <= next_stat;
    end
  end

  // ==========================================================================
  // Register read path
  logic [`DPSC_DATA_W-1:0] next_rdata;
  logic                    next_rvalid;

  always_comb begin
    next_rdata  = 8'h00;
    next_rvalid = REG_RD;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `DPSC_OFS_REFRX: begin
          next_rdata[`DPSC_BIT_PWRDN] = ctrl.refrx_powerdown;
          next_rdata[`DPSC_BIT_HYSEN] = ctrl.hysteresis_enable;
          next_rdata[`DPSC_BIT_EDGE]  = ctrl.ref_sample_edge_select;
          next_rdata[1:0]             = ctrl.hysteresis_thermometer[9:8];
        end
        `DPSC_OFS_HYSLO: begin
          next_rdata = ctrl.hysteresis_thermometer[7:0];
        end
        `DPSC_OFS_PLLCTL: begin
          next_rdata[`DPSC_BIT_RECAL] = ctrl.pll_recalibrate;
          next_rdata[`DPSC_BIT_SYNTH] = ctrl.synth_enable;
        end
        `DPSC_OFS_PLLSTAT: begin
          next_rdata[`DPSC_BIT_BANDHI] = stat.pll_band_high_flag;
          next_rdata[`DPSC_BIT_BANDLO] = stat.pll_band_low_flag;
          next_rdata[`DPSC_BIT_CALOK]  = stat.pll_calibrated_flag;
          next_rdata[`DPSC_BIT_LOCK]   = stat.pll_locked_flag;
        end
        `DPSC_OFS_INTDIV: begin
          next_rdata = ctrl.int_word;
        end
        `DPSC_OFS_LFA: begin
          next_rdata = {ctrl.filter_cap2_word, ctrl.filter_cap1_word};
        end
        `DPSC_OFS_LFB: begin
          next_rdata = {ctrl.filter_res1_word, ctrl.filter_cap3_word};
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RDATA  <= next_rdata;
      REG_RVALID <= next_rvalid;
    end
  end

  // ==========================================================================
  // Frequency plan
  // Codes outside the documented sets give zero so a consumer can spot them.
  dpsc_freq_t next_freq;
  logic [8:0] loop_mult;

  always_comb begin
    loop_mult          = {ctrl.int_word, 1'b0};
    next_freq.dac_mult = loop_mult;
    unique case (VCO_DIVIDER_SELECT)
      2'h1:    next_freq.vco_mult = {2'h0, loop_mult, 2'h0};
      2'h2:    next_freq.vco_mult = {1'h0, loop_mult, 3'h0};
      2'h3:    next_freq.vco_mult = {loop_mult, 4'h0};
      default: next_freq.vco_mult = 13'h0000;
    endcase
    unique case (REFERENCE_DIVISION_RATIO)
      3'h0:    next_freq.ref_div = 5'h01;
      3'h1:    next_freq.ref_div = 5'h02;
      3'h2:    next_freq.ref_div = 5'h04;
      3'h3:    next_freq.ref_div = 5'h08;
      3'h4:    next_freq.ref_div = 5'h10;
      default: next_freq.ref_div = 5'h00;
    endcase
  end

  // ==========================================================================
  // Output stage
  // Every output is a flop, so analog controls lag the register by one cycle; CAL_START lags by two, through the edge detector.
  logic [9:0]  next_hys_applied;
  logic        next_cal_start;
  logic [15:0] next_loop_filter;

  always_comb begin
    next_hys_applied = ctrl.hysteresis_enable ? ctrl.hysteresis_thermometer : 10'h000;
    // Calibration only runs while the synthesizer is enabled.
    next_cal_start   = ctrl.synth_enable & (recal_pulse | enable_pulse);
    next_loop_filter = {ctrl.filter_cap2_word, ctrl.filter_cap1_word,
                        ctrl.filter_res1_word, ctrl.filter_cap3_word};
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      REFRX_POWERDOWN    <= `DPSC_RST_PWRDN;
      HYSTERESIS_ENABLE  <= 1'b0;
      HYSTERESIS_APPLIED <= 10'h000;
      REF_SAMPLE_RISE    <= 1'b0;
      SYNTH_ENABLE       <= 1'b0;
      CAL_START          <= 1'b0;
      FEEDBACK_DIVIDER   <= `DPSC_RST_INTDIV;
      LOOP_FILTER        <= {4{`DPSC_RST_LFWORD}};
      FREQ_PLAN          <= '0;
    end else begin
      REFRX_POWERDOWN    <= ctrl.refrx_powerdown;
      HYSTERESIS_ENABLE  <= ctrl.hysteresis_enable;
      HYSTERESIS_APPLIED <= next_hys_applied;
      REF_SAMPLE_RISE    <= ctrl.ref_sample_edge_select;
      SYNTH_ENABLE       <= ctrl.synth_enable;
      CAL_START          <= next_cal_start;
      FEEDBACK_DIVIDER   <= ctrl.int_word;
      LOOP_FILTER        <= next_loop_filter;
      FREQ_PLAN          <= next_freq;
    end
  end

endmodule : dpsc_regs

// ==== rtl/dpsc_rise_det.sv ====
// Registered rising-edge detector for a control level.
`timescale 1ns/100ps
module dpsc_rise_det (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Level in, one-cycle pulse out
  input  wire logic level,
  output logic      pulse
);

  logic prev;
  logic next_prev;
  logic next_pulse;

  always_comb begin
    next_prev  = level;
    next_pulse = level & ~prev;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prev  <= 1'b0;
      pulse <= 1'b0;
    end else begin
      prev  <= next_prev;
      pulse <= next_pulse;
    end
  end

endmodule : dpsc_rise_det

// ==== tb/dpsc_regs_assertions.sv ====
// Concurrent checks on the ports of the PLL and reference control registers.
`timescale 1ns/100ps
`include "dpsc_defs.svh"
module dpsc_regs_assertions
  import dpsc_pkg::*;
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESET,
  // Register port
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [11:0] REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        REG_RVALID,
  // Status in, controls out
  input wire dpsc_stat_t  PLL_STATUS,
  input wire logic        REFRX_POWERDOWN,
  input wire logic        HYSTERESIS_ENABLE,
  input wire logic [9:0]  HYSTERESIS_APPLIED,
  input wire logic        SYNTH_ENABLE,
  input wire logic        CAL_START,
  input wire logic [7:0]  FEEDBACK_DIVIDER,
  input wire dpsc_freq_t  FREQ_PLAN
);
  // ==========================================================================
  // Sequences
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_wr(a);
    REG_WR && REG_ADDR == a;
  endsequence
  sequence s_stat_rd;
    REG_RD && REG_ADDR == `DPSC_OFS_PLLSTAT && $stable(PLL_STATUS);
  endsequence
  // ==========================================================================
  // Properties
  a_rvalid_pulse: assert property (REG_RVALID == $past(REG_RD)) else $error("rvalid wrong");
  a_status_mirror: assert property (s_stat_rd |=>
    REG_RDATA == {$past(PLL_STATUS[3:1]), 3'h0, $past(PLL_STATUS[0]), 1'h0})
    else $error("status read wrong");
  a_pwrdn_follow: assert property (s_wr(`DPSC_OFS_REFRX) |=> ##1
    REFRX_POWERDOWN == $past(REG_WDATA[4], 2)) else $error("powerdown wrong");
  a_hys_gated: assert property (!HYSTERESIS_ENABLE |-> HYSTERESIS_APPLIED == 10'h000)
    else $error("hysteresis not gated");
  a_synth_follow: assert property (s_wr(`DPSC_OFS_PLLCTL) |=> ##1
    SYNTH_ENABLE == $past(REG_WDATA[4], 2)) else $error("enable wrong");
  a_enable_cal: assert property ($rose(SYNTH_ENABLE) |=> CAL_START)
    else $error("no calibration on enable");
  a_cal_single: assert property (CAL_START |=> !CAL_START) else $error("cal pulse long");
  a_div_follow: assert property (s_wr(`DPSC_OFS_INTDIV) |=> ##1
    FEEDBACK_DIVIDER == $past(REG_WDATA, 2)) else $error("divider wrong");
  // Both outputs are registered from the same stored word, so after the first edge out of
  // reset they must agree in every cycle; the reset value of the plan is zero.
  a_plan_mult: assert property (!$past(RESET) |->
    FREQ_PLAN.dac_mult == {FEEDBACK_DIVIDER, 1'h0}) else $error("dac mult wrong");
endmodule : dpsc_regs_assertions

bind dpsc_regs dpsc_regs_assertions dpsc_regs_assertions_i (.CLK, .RESET, .REG_WR, .REG_RD,
  .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_RVALID, .PLL_STATUS, .REFRX_POWERDOWN,
  .HYSTERESIS_ENABLE, .HYSTERESIS_APPLIED, .SYNTH_ENABLE, .CAL_START, .FEEDBACK_DIVIDER,
  .FREQ_PLAN);

// ==== tb/testbench.sv ====
// Self-checking bench for the PLL and reference control registers.
`timescale 1ns/100ps
`include "dpsc_defs.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module testbench
  import dpsc_pkg::*;
;
  // ==========================================================================
  // Signals
  logic        clk = 1'h0;
  logic        reset = 1'h1;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic [1:0]  vco_sel = 2'h0;
  logic [2:0]  ref_code = 3'h0;
  dpsc_stat_t  pll_status = 4'h0;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid, refrx_pd, hys_en, ref_rise, synth_en, cal_start;
  logic [9:0]  hys_applied;
  logic [7:0]  fb_div;
  logic [15:0] loop_filter;
  dpsc_freq_t  freq_plan;
  int          bad_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          cal_count = 0;

  dpsc_regs dpsc_regs_i (.CLK(clk), .RESET(reset), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .REG_RVALID(reg_rvalid), .VCO_DIVIDER_SELECT(vco_sel),
    .REFERENCE_DIVISION_RATIO(ref_code), .PLL_STATUS(pll_status),
    .REFRX_POWERDOWN(refrx_pd), .HYSTERESIS_ENABLE(hys_en), .HYSTERESIS_APPLIED(hys_applied),
    .REF_SAMPLE_RISE(ref_rise), .SYNTH_ENABLE(synth_en), .CAL_START(cal_start),
    .FEEDBACK_DIVIDER(fb_div), .LOOP_FILTER(loop_filter), .FREQ_PLAN(freq_plan));

  always #2.5 clk = ~clk;

  // Calibration pulses are counted here so a stray or missing one is seen whenever it lands.
  // Sampled on the falling edge, half a cycle after the design launches the pulse.
  always @(negedge clk) begin
    cycles++;
    if (cal_start === 1'h1) cal_count++;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ==========================================================================
  // Access tasks
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_wr = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr = 1'h0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string n);
    @(posedge clk) #1;
    reg_rd = 1'h1;
    reg_addr = a;
    @(posedge clk) #1;
    reg_rd = 1'h0;
    for (int i = 0; i < 3 && reg_rvalid !== 1'h1; i++) @(posedge clk) #1;
    `CHK("rvalid", 1'h1, reg_rvalid)
    `CHK(n, e, reg_rdata)
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Tests
  initial begin
    repeat (5) @(posedge clk);
    #1;
    reset = 1'h0;
    `CHK("pwrdn", 1'h1, refrx_pd)
    `CHK("filter", 16'h8888, loop_filter)
    rd(`DPSC_OFS_REFRX, 8'h10, "refrx");
    rd(`DPSC_OFS_HYSLO, 8'h00, "hyslo");
    rd(`DPSC_OFS_PLLCTL, 8'h00, "pllctl");
    rd(`DPSC_OFS_PLLSTAT, 8'h00, "status");
    rd(`DPSC_OFS_INTDIV, 8'h08, "intdiv");
    rd(`DPSC_OFS_LFA, 8'h88, "lfa");
    rd(`DPSC_OFS_LFB, 8'h88, "lfb");
    $display("test reset done");
    wr(`DPSC_OFS_REFRX, 8'hff);
    wr(`DPSC_OFS_HYSLO, 8'ha5);
    wr(`DPSC_OFS_PLLSTAT, 8'hff);
    wr(12'h086, 8'hff);
    idle(2);
    `CHK("hysen", 1'h1, hys_en)
    `CHK("hys", 10'h3a5, hys_applied)
    `CHK("rise", 1'h1, ref_rise)
    rd(`DPSC_OFS_REFRX, 8'h1f, "refrx");
    rd(`DPSC_OFS_PLLSTAT, 8'h00, "status");
    rd(12'h086, 8'h00, "unmapped");
    rd(12'h089, 8'h00, "unmapped");
    wr(`DPSC_OFS_REFRX, 8'h03);
    idle(2);
    `CHK("pwrdn", 1'h0, refrx_pd)
    `CHK("hysen", 1'h0, hys_en)
    `CHK("hys", 10'h000, hys_applied)
    `CHK("rise", 1'h0, ref_rise)
    $display("test receiver done");
    wr(`DPSC_OFS_PLLCTL, 8'h10);
    idle(4);
    `CHK("synth", 1'h1, synth_en)
    `CHK("cals", 1, cal_count)
    wr(`DPSC_OFS_PLLCTL, 8'h90);
    wr(`DPSC_OFS_PLLCTL, 8'h90);
    idle(4);
    `CHK("cals", 2, cal_count)
    wr(`DPSC_OFS_PLLCTL, 8'h10);
    wr(`DPSC_OFS_PLLCTL, 8'hff);
    idle(4);
    `CHK("cals", 3, cal_count)
    rd(`DPSC_OFS_PLLCTL, 8'h90, "pllctl");
    wr(`DPSC_OFS_PLLCTL, 8'h00);
    idle(4);
    `CHK("synth", 1'h0, synth_en)
    $display("test calibration done");
    for (int i = 0; i < 5; i++) begin
      pll_status = (i == 4) ? 4'hf : 4'h1 << i;
      rd(`DPSC_OFS_PLLSTAT, {pll_status[3:1], 3'h0, pll_status[0], 1'h0}, "status");
    end
    $display("test status done");
    wr(`DPSC_OFS_INTDIV, 8'h06);
    idle(2);
    `CHK("fbdiv", 8'h06, fb_div)
    wr(`DPSC_OFS_INTDIV, 8'hff);
    for (int s = 0; s < 4; s++) begin
      for (int r = 0; r < 8; r++) begin
        vco_sel = s[1:0];
        ref_code = r[2:0];
        idle(3);
        `CHK("dacmult", 9'h1fe, freq_plan.dac_mult)
        `CHK("vcomult", (s == 0) ? 13'h0 : 13'h1fe << (s + 1), freq_plan.vco_mult)
        `CHK("refdiv", (r < 5) ? 5'h1 << r : 5'h0, freq_plan.ref_div)
      end
    end
    $display("test divider done");
    wr(`DPSC_OFS_LFA, 8'h62);
    wr(`DPSC_OFS_LFB, 8'hc9);
    idle(2);
    `CHK("filter", 16'h62c9, loop_filter)
    rd(`DPSC_OFS_LFB, 8'hc9, "lfb");
    $display("test filter done");
    wrap_up();
  end
endmodule : testbench
